// ---- hdl/cfu_unpacker.sv ----
// Configuration flag unpacker: takes three flag words and a signature byte
// from the memory reader, spreads them into register defaults and shows
// the results over an APB slave.
// Assumes memory reader logic on sys_clk delivers words with a strobe.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module cfu_unpacker (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// Memory reader side
	input  wire logic        memValid,
	input  wire logic [7:0]  memSignature,
	input  wire logic [31:0] memWord0,
	input  wire logic [31:0] memWord1,
	input  wire logic [31:0] memWord2,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Defaults driven to neighbouring blocks
	output logic             suspend_allow,
	output logic [1:0]       flag_sleep_pin_choice,
	output logic             flag_sleep_pin_polarity,
	output logic             flag_auto_duplex,
	output logic             flag_auto_speed,
	output logic [1:0]       enhanced_sleep_interval,
	output logic [1:0]       enhanced_wake_interval,
	output logic [1:0]       linkTimeoutCtrl,
	output logic             enhanced_phy_on,
	output logic             common_pll_low_power,
	output logic [2:0]       flag_hs_drive_current,
	output logic             flag_lane_swap,
	output logic             flag_link_pm_capable,
	output logic             flag_remote_wake,
	output logic             flag_power_source,
	output logic             lfps_overlap_check,
	output logic             u2_exit_signalling,
	output logic             oscillator_keep_running,
	output logic [3:0]       flag_out_burst_limit,
	output logic [3:0]       flag_in_burst_limit,
	output logic             utmi_sleep_allow,
	output logic             pipeTxSwing,
	output logic [2:0]       pipeTxMargin,
	output logic [1:0]       pipeTxDeemph,
	output logic             pipeElasticMode,
	output logic [7:0]       u1_idle_timeout,
	output logic [4:0]       resume_duration_threshold,
	output logic             auto_duplex_polarity,
	output logic             green_link_up_speedup,
	output logic             green_tx_clock_halt,
	output logic             green_ethernet_on,
	output logic             green_idle_auto_clear,
	output logic             loadDone,
	output logic             memPresent
);

	cfu_pkg::cfu_state_t stateQ;
	logic [31:0]         word0Q;
	logic [31:0]         word1Q;
	logic [31:0]         word2Q;
	logic                complianceQ;
	logic [1:0]          ltssmDeemphQ;
	logic                presentQ;

	wire logic sigOk = (memSignature == cfu_pkg::SIGNATURE);
	wire logic apbWr = psel && penable && pwrite;
	wire logic apbRd = psel && !penable && !pwrite;
	wire logic ctrlWr = apbWr && (paddr == cfu_pkg::OFF_CTRL);

	// Loader sequence: one load per reset, or again on software request
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			stateQ <= cfu_pkg::ST_IDLE;
		end else begin
			case (stateQ)
				cfu_pkg::ST_IDLE: begin
					if (memValid) begin
						stateQ <= sigOk ? cfu_pkg::ST_LOAD
						                : cfu_pkg::ST_SKIP;
					end
				end
				cfu_pkg::ST_LOAD: stateQ <= cfu_pkg::ST_DONE;
				cfu_pkg::ST_SKIP: stateQ <= cfu_pkg::ST_DONE;
				cfu_pkg::ST_DONE: begin
					if (ctrlWr && pwdata[cfu_pkg::CTRL_LOAD]) begin
						stateQ <= cfu_pkg::ST_IDLE;
					end
				end
				default: stateQ <= cfu_pkg::ST_IDLE;
			endcase
		end
	end

	// Flag words held with reserved bits cleared, so nothing downstream
	// ever sees them. A skipped load puts the built-in defaults back, so a
	// reload without signature cannot leave an older image in force.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			word0Q   <= cfu_pkg::DEF_WORD0;
			word1Q   <= cfu_pkg::DEF_WORD1;
			word2Q   <= cfu_pkg::DEF_WORD2;
			presentQ <= 1'b0;
		end else if (stateQ == cfu_pkg::ST_IDLE && memValid) begin
			presentQ <= sigOk;
			if (sigOk) begin
				word0Q <= memWord0 & cfu_pkg::MASK_WORD0;
				word1Q <= memWord1 & cfu_pkg::MASK_WORD1;
				word2Q <= memWord2 & cfu_pkg::MASK_WORD2;
			end else begin
				word0Q <= cfu_pkg::DEF_WORD0;
				word1Q <= cfu_pkg::DEF_WORD1;
				word2Q <= cfu_pkg::DEF_WORD2;
			end
		end
	end

	// Link state from software: compliance mode and training de-emphasis
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			complianceQ  <= 1'b0;
			ltssmDeemphQ <= 2'b00;
		end else if (ctrlWr) begin
			complianceQ  <= pwdata[cfu_pkg::CTRL_COMPL];
			ltssmDeemphQ <= pwdata[cfu_pkg::CTRL_LTSSM +: 2];
		end
	end

	// Spread the words into the target fields
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			suspend_allow             <= 1'b0;
			flag_sleep_pin_choice     <= 2'b00;
			flag_sleep_pin_polarity   <= 1'b0;
			flag_auto_duplex          <= 1'b0;
			flag_auto_speed           <= 1'b0;
			enhanced_sleep_interval   <= 2'b00;
			enhanced_wake_interval    <= 2'b00;
			linkTimeoutCtrl           <= 2'b00;
			enhanced_phy_on           <= 1'b0;
			common_pll_low_power      <= 1'b0;
			flag_hs_drive_current     <= 3'h0;
			flag_lane_swap            <= 1'b0;
			flag_link_pm_capable      <= 1'b0;
			flag_remote_wake          <= 1'b0;
			flag_power_source         <= 1'b0;
			lfps_overlap_check        <= 1'b0;
			u2_exit_signalling        <= 1'b0;
			oscillator_keep_running   <= 1'b0;
			flag_out_burst_limit      <= 4'h0;
			flag_in_burst_limit       <= 4'h0;
			utmi_sleep_allow          <= 1'b0;
			pipeTxSwing               <= 1'b0;
			pipeTxMargin              <= 3'h0;
			pipeTxDeemph              <= 2'b00;
			pipeElasticMode           <= 1'b0;
			u1_idle_timeout           <= 8'h00;
			resume_duration_threshold <= 5'h00;
			auto_duplex_polarity      <= 1'b0;
			green_link_up_speedup     <= 1'b0;
			green_tx_clock_halt       <= 1'b0;
			green_ethernet_on         <= 1'b0;
			green_idle_auto_clear     <= 1'b0;
		end else begin
			suspend_allow <= word0Q[cfu_pkg::W0_SUSP];
			flag_sleep_pin_choice <=
				word0Q[cfu_pkg::W0_SELH:cfu_pkg::W0_SELL];
			flag_sleep_pin_polarity <= word0Q[cfu_pkg::W0_POL];
			flag_auto_duplex <= word0Q[cfu_pkg::W0_ADD];
			flag_auto_speed  <= word0Q[cfu_pkg::W0_ASD];
			enhanced_sleep_interval <=
				word0Q[cfu_pkg::W0_SLPH:cfu_pkg::W0_SLPL];
			enhanced_wake_interval <=
				word0Q[cfu_pkg::W0_WAKH:cfu_pkg::W0_WAKL];
			linkTimeoutCtrl <=
				word0Q[cfu_pkg::W0_LTOH:cfu_pkg::W0_LTOL];
			enhanced_phy_on <= word0Q[cfu_pkg::W0_ENH];
			common_pll_low_power <= word0Q[cfu_pkg::W0_LPM];
			flag_hs_drive_current <=
				word0Q[cfu_pkg::W0_BSTH:cfu_pkg::W0_BSTL];
			flag_lane_swap       <= word0Q[cfu_pkg::W0_SWAP];
			flag_link_pm_capable <= word0Q[cfu_pkg::W0_LPMCAP];
			flag_remote_wake     <= word0Q[cfu_pkg::W0_RWAKE];
			flag_power_source    <= word0Q[cfu_pkg::W0_PWR];
			// Both words carry the same two USB bits; either one set wins
			lfps_overlap_check <= word1Q[cfu_pkg::W1_OVL] |
			                      word2Q[cfu_pkg::W2_OVL];
			u2_exit_signalling <= word1Q[cfu_pkg::W1_U2X] |
			                      word2Q[cfu_pkg::W2_U2X];
			oscillator_keep_running <= word1Q[cfu_pkg::W1_XTAL];
			flag_out_burst_limit <=
				word1Q[cfu_pkg::W1_OUTH:cfu_pkg::W1_OUTL];
			flag_in_burst_limit <=
				word1Q[cfu_pkg::W1_INH:cfu_pkg::W1_INL];
			utmi_sleep_allow <= word1Q[cfu_pkg::W1_SLPM];
			pipeTxSwing <= word1Q[cfu_pkg::W1_SWING];
			pipeTxMargin <=
				word1Q[cfu_pkg::W1_MARH:cfu_pkg::W1_MARL];
			pipeTxDeemph <= complianceQ ? ltssmDeemphQ
				: word1Q[cfu_pkg::W1_DEH:cfu_pkg::W1_DEL];
			// Stored only; the Gen 1 front end ignores it
			pipeElasticMode <= word1Q[cfu_pkg::W1_EBM];
			u1_idle_timeout <=
				word2Q[cfu_pkg::W2_U1H:cfu_pkg::W2_U1L];
			resume_duration_threshold <=
				word2Q[cfu_pkg::W2_HIRDH:cfu_pkg::W2_HIRDL];
			auto_duplex_polarity  <= word2Q[cfu_pkg::W2_ADP];
			green_link_up_speedup <= word2Q[cfu_pkg::W2_SPDUP];
			green_tx_clock_halt   <= word2Q[cfu_pkg::W2_TXSTOP];
			green_ethernet_on     <= word2Q[cfu_pkg::W2_EEE];
			green_idle_auto_clear <= word2Q[cfu_pkg::W2_LPICLR];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			loadDone   <= 1'b0;
			memPresent <= 1'b0;
		end else begin
			loadDone   <= (stateQ == cfu_pkg::ST_DONE);
			memPresent <= presentQ;
		end
	end

	// APB: read data is registered in setup, so every access takes one
	// wait-free access phase; unmapped addresses answer with an error.
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= cfu_pkg::OFF_MISC) && (a[1:0] == 2'b00);
	endfunction : mapped

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped(paddr);
			if (apbRd) begin
				case (paddr)
					cfu_pkg::OFF_CTRL: prdata <= {29'h0, ltssmDeemphQ,
					                              complianceQ};
					cfu_pkg::OFF_STATUS: prdata <= {30'h0, presentQ,
						stateQ == cfu_pkg::ST_DONE};
					cfu_pkg::OFF_WORD0: prdata <= word0Q;
					cfu_pkg::OFF_WORD1: prdata <= word1Q;
					cfu_pkg::OFF_WORD2: prdata <= word2Q;
					cfu_pkg::OFF_USB0: prdata <= {11'h0,
						resume_duration_threshold, flag_out_burst_limit,
						flag_in_burst_limit, utmi_sleep_allow,
						lfps_overlap_check, u2_exit_signalling,
						suspend_allow, flag_lane_swap,
						flag_link_pm_capable, flag_remote_wake,
						flag_power_source};
					cfu_pkg::OFF_USB1: prdata <= {24'h0, u1_idle_timeout};
					cfu_pkg::OFF_HW: prdata <= {28'h0,
						green_link_up_speedup, flag_sleep_pin_choice,
						flag_sleep_pin_polarity};
					cfu_pkg::OFF_MAC: prdata <= {26'h0, flag_auto_duplex,
						flag_auto_speed, auto_duplex_polarity,
						green_tx_clock_halt, green_ethernet_on,
						green_idle_auto_clear};
					cfu_pkg::OFF_PMT: prdata <= {31'h0,
						oscillator_keep_running};
					cfu_pkg::OFF_PIPE: prdata <= {25'h0, pipeTxSwing,
						pipeTxMargin, pipeTxDeemph, pipeElasticMode};
					cfu_pkg::OFF_PHY: prdata <= {25'h0,
						enhanced_sleep_interval, enhanced_wake_interval,
						linkTimeoutCtrl, enhanced_phy_on};
					cfu_pkg::OFF_MISC: prdata <= {28'h0,
						common_pll_low_power, flag_hs_drive_current};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Checks
	sequence SEQ_GOOD_LOAD;
		stateQ == cfu_pkg::ST_IDLE && memValid && sigOk;
	endsequence

	sequence SEQ_BAD_LOAD;
		stateQ == cfu_pkg::ST_IDLE && memValid && !sigOk;
	endsequence

	AST_SIG_GATES: assert property (@(posedge sys_clk) disable iff (!reset_n)
		SEQ_BAD_LOAD |=> word0Q == cfu_pkg::DEF_WORD0
		&& word1Q == cfu_pkg::DEF_WORD1
		&& word2Q == cfu_pkg::DEF_WORD2)
		else $error("Words not at defaults without signature");
	AST_NOT_PRESENT: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		SEQ_BAD_LOAD |=> ##1 !memPresent)
		else $error("Memory shown present without signature");
	AST_LOAD_W0: assert property (@(posedge sys_clk) disable iff (!reset_n)
		SEQ_GOOD_LOAD |=> ##1
		suspend_allow == $past(memWord0[cfu_pkg::W0_SUSP], 2)
		&& flag_power_source == $past(memWord0[cfu_pkg::W0_PWR], 2))
		else $error("Word zero bits not copied");
	AST_PIN_SEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
		flag_sleep_pin_choice ==
		$past(word0Q[cfu_pkg::W0_SELH:cfu_pkg::W0_SELL]))
		else $error("Pin choice mismatch");
	AST_PHY_ON: assert property (@(posedge sys_clk) disable iff (!reset_n)
		enhanced_phy_on == $past(word0Q[cfu_pkg::W0_ENH])
		&& linkTimeoutCtrl ==
		$past(word0Q[cfu_pkg::W0_LTOH:cfu_pkg::W0_LTOL]))
		else $error("Enhanced PHY defaults mismatch");
	AST_BURST: assert property (@(posedge sys_clk) disable iff (!reset_n)
		flag_out_burst_limit ==
		$past(word1Q[cfu_pkg::W1_OUTH:cfu_pkg::W1_OUTL])
		&& flag_in_burst_limit ==
		$past(word1Q[cfu_pkg::W1_INH:cfu_pkg::W1_INL]))
		else $error("Burst limits mismatch");
	AST_COMPL: assert property (@(posedge sys_clk) disable iff (!reset_n)
		complianceQ |=> pipeTxDeemph == $past(ltssmDeemphQ))
		else $error("Compliance de-emphasis not from training");
	AST_U1: assert property (@(posedge sys_clk) disable iff (!reset_n)
		u1_idle_timeout ==
		$past(word2Q[cfu_pkg::W2_U1H:cfu_pkg::W2_U1L]))
		else $error("U1 timeout mismatch");
	AST_RSVD: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(word0Q & ~cfu_pkg::MASK_WORD0) == 32'h0000_0000
		&& (word1Q & ~cfu_pkg::MASK_WORD1) == 32'h0000_0000
		&& (word2Q & ~cfu_pkg::MASK_WORD2) == 32'h0000_0000)
		else $error("Reserved bits stored");
	AST_GREEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		green_ethernet_on == $past(word2Q[cfu_pkg::W2_EEE])
		&& auto_duplex_polarity == $past(word2Q[cfu_pkg::W2_ADP]))
		else $error("Green Ethernet bits mismatch");

endmodule : cfu_unpacker

// ---- inc/cfu_pkg.sv ----
// Package for the configuration flag unpacker: flag word field layout,
// APB register offsets and reset defaults.
// Assumes a 32-bit APB slave and three 32-bit flag words from memory.
package cfu_pkg;

	localparam int unsigned CLK_HZ = 25000000;

	// Signature that marks a programmed configuration memory
	localparam logic [7:0] SIGNATURE = 8'ha5;

	// APB byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_WORD0  = 8'h08;
	localparam logic [7:0] OFF_WORD1  = 8'h0c;
	localparam logic [7:0] OFF_WORD2  = 8'h10;
	localparam logic [7:0] OFF_USB0   = 8'h14;
	localparam logic [7:0] OFF_USB1   = 8'h18;
	localparam logic [7:0] OFF_HW     = 8'h1c;
	localparam logic [7:0] OFF_MAC    = 8'h20;
	localparam logic [7:0] OFF_PMT    = 8'h24;
	localparam logic [7:0] OFF_PIPE   = 8'h28;
	localparam logic [7:0] OFF_PHY    = 8'h2c;
	localparam logic [7:0] OFF_MISC   = 8'h30;

	// Control register bits
	localparam int CTRL_LOAD  = 0;
	localparam int CTRL_COMPL = 1;
	localparam int CTRL_LTSSM = 2; // 3:2 de-emphasis from link training

	// Word zero fields
	localparam int W0_SUSP    = 20;
	localparam int W0_SELH    = 19;
	localparam int W0_SELL    = 18;
	localparam int W0_POL     = 17;
	localparam int W0_ADD     = 16;
	localparam int W0_ASD     = 15;
	localparam int W0_SLPH    = 14;
	localparam int W0_SLPL    = 13;
	localparam int W0_WAKH    = 12;
	localparam int W0_WAKL    = 11;
	localparam int W0_LTOH    = 10;
	localparam int W0_LTOL    = 9;
	localparam int W0_ENH     = 8;
	localparam int W0_LPM     = 7;
	localparam int W0_BSTH    = 6;
	localparam int W0_BSTL    = 4;
	localparam int W0_SWAP    = 3;
	localparam int W0_LPMCAP  = 2;
	localparam int W0_RWAKE   = 1;
	localparam int W0_PWR     = 0;
	// Word one fields
	localparam int W1_OVL     = 18;
	localparam int W1_U2X     = 17;
	localparam int W1_XTAL    = 16;
	localparam int W1_OUTH    = 15;
	localparam int W1_OUTL    = 12;
	localparam int W1_INH     = 11;
	localparam int W1_INL     = 8;
	localparam int W1_SLPM    = 7;
	localparam int W1_SWING   = 6;
	localparam int W1_MARH    = 5;
	localparam int W1_MARL    = 3;
	localparam int W1_DEH     = 2;
	localparam int W1_DEL     = 1;
	localparam int W1_EBM     = 0;
	// Word two fields
	localparam int W2_U1H     = 31;
	localparam int W2_U1L     = 24;
	localparam int W2_HIRDH   = 20;
	localparam int W2_HIRDL   = 16;
	localparam int W2_OVL     = 15;
	localparam int W2_U2X     = 14;
	localparam int W2_ADP     = 13;
	localparam int W2_SPDUP   = 12;
	localparam int W2_TXSTOP  = 11;
	localparam int W2_EEE     = 10;
	localparam int W2_LPICLR  = 9;

	// Built-in defaults kept when no signature is found
	localparam logic [31:0] DEF_WORD0 = 32'h0000_0000;
	localparam logic [31:0] DEF_WORD1 = 32'h0000_0000;
	localparam logic [31:0] DEF_WORD2 = 32'h0000_0000;

	// Valid bits in each word; reserved bits are masked
	localparam logic [31:0] MASK_WORD0 = 32'h001f_ffff;
	localparam logic [31:0] MASK_WORD1 = 32'h0007_ffff;
	localparam logic [31:0] MASK_WORD2 = 32'hff1f_fe00;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_SKIP = 2'b10,
		ST_DONE = 2'b11
	} cfu_state_t;

endpackage : cfu_pkg

// ---- sim/cfu_mem_model.sv ----
// Memory reader stand-in: presents a signature byte and three flag words
// with a valid level for three cycles after each start pulse.
// Assumes the bench supplies the image; outside the valid window the data
// lines toggle so stale values are never mistaken for fresh ones.
`timescale 1ns/1ps
module cfu_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic [7:0]  sigIn,
	input  wire logic [31:0] word0In,
	input  wire logic [31:0] word1In,
	input  wire logic [31:0] word2In,
	output logic             memValid,
	output logic [7:0]       memSignature,
	output logic [31:0]      memWord0,
	output logic [31:0]      memWord1,
	output logic [31:0]      memWord2
);
	logic [1:0] holdCnt_q;

	// Held three cycles so a reload that reaches idle late still sees it
	always_ff @(posedge sys_clk) begin
		if (!reset_n)
			holdCnt_q <= 2'h0;
		else if (start)
			holdCnt_q <= 2'h3;
		else if (holdCnt_q != 2'h0)
			holdCnt_q <= holdCnt_q - 2'h1;
	end

	assign memValid = (holdCnt_q != 2'h0);

	always_ff @(posedge sys_clk) begin
		if (start || holdCnt_q > 2'h1) begin
			memSignature <= sigIn;
			memWord0     <= word0In;
			memWord1     <= word1In;
			memWord2     <= word2In;
		end else begin
			memSignature <= ~memSignature;
			memWord0     <= ~memWord0;
			memWord1     <= ~memWord1;
			memWord2     <= ~memWord2;
		end
	end
endmodule : cfu_mem_model

// ---- sim/testbench.sv ----
// Self-checking bench for the flag unpacker: random images, reloads, a
// load without signature, compliance de-emphasis and APB readback.
// Assumes the memory model and the unpacker share one 25 MHz clock.
`timescale 1ns/1ps
module testbench;
	logic        sys_clk, reset_n, psel, penable, pwrite, start, er, ok;
	logic [7:0]  paddr, sigIn, memSignature, u1_idle_timeout;
	logic [31:0] pwdata, prdata, rd, w0, w1, w2, e0, e1, e2;
	logic [31:0] memWord0, memWord1, memWord2;
	logic        memValid, pready, pslverr, loadDone, memPresent;
	logic        suspend_allow, flag_sleep_pin_polarity, flag_auto_duplex;
	logic        flag_auto_speed, enhanced_phy_on, common_pll_low_power;
	logic        flag_lane_swap, flag_link_pm_capable, flag_remote_wake;
	logic        flag_power_source, lfps_overlap_check, u2_exit_signalling;
	logic        oscillator_keep_running, utmi_sleep_allow, pipeTxSwing;
	logic        pipeElasticMode, auto_duplex_polarity, green_link_up_speedup;
	logic        green_tx_clock_halt, green_ethernet_on, green_idle_auto_clear;
	logic [1:0]  flag_sleep_pin_choice, enhanced_sleep_interval;
	logic [1:0]  enhanced_wake_interval, linkTimeoutCtrl, pipeTxDeemph;
	logic [2:0]  flag_hs_drive_current, pipeTxMargin;
	logic [3:0]  flag_out_burst_limit, flag_in_burst_limit;
	logic [4:0]  resume_duration_threshold;
	int          n_fail, n_tests, seed, i, d;

	cfu_mem_model i_cfu_mem_model (.sys_clk, .reset_n, .start, .sigIn,
		.word0In(w0), .word1In(w1), .word2In(w2), .memValid, .memSignature,
		.memWord0, .memWord1, .memWord2);

	cfu_unpacker i_cfu_unpacker (.sys_clk, .reset_n, .memValid,
		.memSignature, .memWord0, .memWord1, .memWord2, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .suspend_allow,
		.flag_sleep_pin_choice, .flag_sleep_pin_polarity, .flag_auto_duplex,
		.flag_auto_speed, .enhanced_sleep_interval, .enhanced_wake_interval,
		.linkTimeoutCtrl, .enhanced_phy_on, .common_pll_low_power,
		.flag_hs_drive_current, .flag_lane_swap, .flag_link_pm_capable,
		.flag_remote_wake, .flag_power_source, .lfps_overlap_check,
		.u2_exit_signalling, .oscillator_keep_running, .flag_out_burst_limit,
		.flag_in_burst_limit, .utmi_sleep_allow, .pipeTxSwing, .pipeTxMargin,
		.pipeTxDeemph, .pipeElasticMode, .u1_idle_timeout,
		.resume_duration_threshold, .auto_duplex_polarity,
		.green_link_up_speedup, .green_tx_clock_halt, .green_ethernet_on,
		.green_idle_auto_clear, .loadDone, .memPresent);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	task automatic cmp(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp

	function automatic int unsigned f(input logic [31:0] w, input int lo,
		input int n);
		return (w >> lo) & ((1 << n) - 1);
	endfunction : f

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] dat, output logic [31:0] r, output logic e);
		int k;
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= dat;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		if (k == 16) begin
			n_fail++;
			results();
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
		input logic xe, input string nm);
		apb(1'b0, a, 32'h0, rd, er);
		cmp(nm, exp, rd);
		cmp(nm, {31'h0, xe}, {31'h0, er});
	endtask : rdc

	task automatic chk;
		cmp("susp", f(e0, 20, 1), suspend_allow);
		cmp("pin", f(e0, 17, 3), {flag_sleep_pin_choice,
			flag_sleep_pin_polarity});
		cmp("autodet", f(e0, 15, 2), {flag_auto_duplex, flag_auto_speed});
		cmp("timers", f(e0, 11, 4), {enhanced_sleep_interval,
			enhanced_wake_interval});
		cmp("linkto", f(e0, 9, 2), linkTimeoutCtrl);
		cmp("enh", f(e0, 8, 1), enhanced_phy_on);
		cmp("afe", f(e0, 4, 4), {common_pll_low_power,
			flag_hs_drive_current});
		cmp("usb0", f(e0, 0, 4), {flag_lane_swap, flag_link_pm_capable,
			flag_remote_wake, flag_power_source});
		cmp("ux", ((f(e1, 18, 1) | f(e2, 15, 1)) << 2) | ((f(e1, 17, 1) |
			f(e2, 14, 1)) << 1) | f(e1, 16, 1), {lfps_overlap_check,
			u2_exit_signalling, oscillator_keep_running});
		cmp("burst", f(e1, 8, 8), {flag_out_burst_limit,
			flag_in_burst_limit});
		cmp("pipe", f(e1, 0, 8), {utmi_sleep_allow, pipeTxSwing,
			pipeTxMargin, pipeTxDeemph, pipeElasticMode});
		cmp("u1hird", (f(e2, 24, 8) << 5) | f(e2, 16, 5), {u1_idle_timeout,
			resume_duration_threshold});
		cmp("adp", f(e2, 12, 2), {auto_duplex_polarity,
			green_link_up_speedup});
		cmp("green", f(e2, 9, 3), {green_tx_clock_halt, green_ethernet_on,
			green_idle_auto_clear});
		cmp("present", {31'h0, ok}, {31'h0, memPresent});
		cmp("done", 32'h1, {31'h0, loadDone});
	endtask : chk

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		results();
	end

	initial begin
		seed = 32'hd071;
		n_fail = 0;
		n_tests = 0;
		{reset_n, psel, penable, pwrite, start, paddr, sigIn} = '0;
		{pwdata, w0, w1, w2} = '0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (i = 0; i < 5; i++) begin
			ok = (i != 2);
			sigIn = ok ? 8'ha5 : 8'h5a;
			w0 = $random(seed);
			w1 = $random(seed);
			w2 = $random(seed);
			e0 = ok ? w0 : 32'h0;
			e1 = ok ? w1 : 32'h0;
			e2 = ok ? w2 : 32'h0;
			if (i > 0)
				apb(1'b1, cfu_pkg::OFF_CTRL, 32'h1, rd, er);
			repeat (2) @(posedge sys_clk);
			start <= 1'b1;
			@(posedge sys_clk);
			start <= 1'b0;
			repeat (8) @(posedge sys_clk);
			#1;
			chk();
			rdc(cfu_pkg::OFF_STATUS, {30'h0, ok, 1'b1}, 1'b0, "status");
			rdc(cfu_pkg::OFF_WORD0, e0 & cfu_pkg::MASK_WORD0, 1'b0, "w0");
			rdc(cfu_pkg::OFF_WORD1, e1 & cfu_pkg::MASK_WORD1, 1'b0, "w1");
			rdc(cfu_pkg::OFF_WORD2, e2 & cfu_pkg::MASK_WORD2, 1'b0, "w2");
			rdc(8'h34, 32'h0, 1'b1, "unmapped");
			rdc(cfu_pkg::OFF_USB0, {11'h0, e2[20:16], e1[15:7],
				e1[18] | e2[15], e1[17] | e2[14], e0[20], e0[3:0]},
				1'b0, "usb0");
			rdc(cfu_pkg::OFF_USB1, {24'h0, e2[31:24]}, 1'b0, "usb1");
			rdc(cfu_pkg::OFF_HW, {28'h0, e2[12], e0[19:17]}, 1'b0,
				"hw");
			rdc(cfu_pkg::OFF_MAC, {26'h0, e0[16:15], e2[13], e2[11:9]},
				1'b0, "mac");
			rdc(cfu_pkg::OFF_PMT, {31'h0, e1[16]}, 1'b0, "pmt");
			rdc(cfu_pkg::OFF_PIPE, {25'h0, e1[6:0]}, 1'b0, "pipe");
			rdc(cfu_pkg::OFF_PHY, {25'h0, e0[14:8]}, 1'b0, "phy");
			rdc(cfu_pkg::OFF_MISC, {28'h0, e0[7:4]}, 1'b0, "misc");
			if (i == 1) begin
				for (d = 0; d < 4; d++) begin
					apb(1'b1, cfu_pkg::OFF_CTRL, 32'((d << 2) | 2), rd, er);
					repeat (3) @(posedge sys_clk);
					#1;
					cmp("compl", 32'(d), pipeTxDeemph);
					rdc(cfu_pkg::OFF_CTRL, 32'((d << 1) | 1), 1'b0,
						"ctrl");
				end
				apb(1'b1, cfu_pkg::OFF_CTRL, 32'h0, rd, er);
				repeat (3) @(posedge sys_clk);
				#1;
				cmp("nocompl", f(e1, 1, 2), pipeTxDeemph);
			end
		end
		results();
	end
endmodule : testbench
